/* File: design/lmx_exec.sv */
/*
 * execution of literal loads, file/indirect stores, software reset
 * and return from interrupt. assumes program memory presents one
 * instruction word with instr_valid, taken when instr_ready_r is high;
 * the stack supplies stack_top and pops on stack_pop_r.
 */
`timescale 1ns/1ns
`include "lmx_params.svh"

// Contract
// - bank literal loads six bits, flags untouched
// - page literal loads seven bits to latch
// - work literal loads eight bits, one cycle
// - work literal don't-care bits decode as zero
// - store work to file register, one cycle
// - indirect address: pointer plus one/minus one/offset
// - pointer updates by one, relative leaves it
// - mode 00 preinc,01 predec,10 postinc,11 postdec
// - indirect window redirects to pointer address
// - pointers are 16 bits and wrap
// - pointer updates change no status bits
// - software reset resets device, clears flag
// - return pops stack, loads pc, sets enable
// - global enable sits at irq control bit 7
// - page, bank, reset, return leave flags; reset clears reset_instr_flag_r
module lmx_exec (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    input wire logic [14:0] stack_top,
    output logic instr_ready_r,
    output logic [7:0] work_r,
    output logic [5:0] bank_select_reg_r,
    output logic [6:0] pc_high_latch_r,
    output logic pc_load_r,
    output logic [14:0] pc_value_r,
    output logic stack_pop_r,
    output logic [7:0] irq_control_reg_r,
    output logic mem_we_r,
    output logic mem_indirect_r,
    output logic [15:0] mem_addr_r,
    output logic [7:0] mem_data_r,
    output logic [15:0] ptr0_r,
    output logic [15:0] ptr1_r,
    output logic soft_reset_r,
    output logic reset_instr_flag_r
);
    lmx_pkg::lmx_state_t state_r, state_nxt;
    lmx_pkg::lmx_op_t op;
    logic take, sel, window_hit, rel;
    logic [15:0] sel_ptr, eff_addr, ptr_next;
    logic [5:0] offset;
    function automatic lmx_pkg::lmx_op_t decode(input logic [13:0] w);
        if (w == `LMX_NOP_VAL)
            decode = lmx_pkg::LMX_OP_NOP;
        else if (w == `LMX_SRST_VAL)
            decode = lmx_pkg::LMX_OP_SRST;
        else if (w == `LMX_RETI_VAL)
            decode = lmx_pkg::LMX_OP_RETI;
        else if ((w & `LMX_BANK_MASK) == `LMX_BANK_VAL)
            decode = lmx_pkg::LMX_OP_BANK;
        else if ((w & `LMX_PAGE_MASK) == `LMX_PAGE_VAL)
            decode = lmx_pkg::LMX_OP_PAGE;
        else if ((w & `LMX_WORK_MASK) == `LMX_WORK_VAL)
            decode = lmx_pkg::LMX_OP_WORK;
        else if ((w & `LMX_FILE_MASK) == `LMX_FILE_VAL)
            decode = lmx_pkg::LMX_OP_FILE;
        else if ((w & `LMX_IND_MASK) == `LMX_IND_VAL)
            decode = lmx_pkg::LMX_OP_IND;
        else if ((w & `LMX_REL_MASK) == `LMX_REL_VAL)
            decode = lmx_pkg::LMX_OP_REL;
        else
            decode = lmx_pkg::LMX_OP_OTHER;
    endfunction
    assign op = decode(instr);
    assign take = instr_valid && instr_ready_r && !soft_reset_r;
    assign window_hit = (op == lmx_pkg::LMX_OP_FILE) &&
        ((instr[6:0] == `LMX_WINDOW0_ADDR) ||
        (instr[6:0] == `LMX_WINDOW1_ADDR));
    assign rel = (op != lmx_pkg::LMX_OP_IND);
    assign sel = window_hit ? instr[0] : (op == lmx_pkg::LMX_OP_IND) ?
        instr[`LMX_IND_SEL_BIT] : instr[`LMX_REL_SEL_BIT];
    assign offset = (op == lmx_pkg::LMX_OP_REL) ? instr[5:0] : 6'h00;
    assign sel_ptr = sel ? ptr1_r : ptr0_r;
    lmx_ptr_unit u_ptr (
        .ptr(sel_ptr),
        .pointer_update_mode(instr[1:0]),
        .rel(rel),
        .offset(offset),
        .eff_addr(eff_addr),
        .ptr_next(ptr_next)
    );

    // sequencing: return takes a second cycle
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            lmx_pkg::LMX_ST_RUN:
                if (take && op == lmx_pkg::LMX_OP_RETI)
                    state_nxt = lmx_pkg::LMX_ST_RET2;
            lmx_pkg::LMX_ST_RET2:
                state_nxt = lmx_pkg::LMX_ST_RUN;
            default:
                state_nxt = lmx_pkg::LMX_ST_RUN;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= lmx_pkg::LMX_ST_RUN;
            instr_ready_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            instr_ready_r <= (state_nxt == lmx_pkg::LMX_ST_RUN) &&
                !(take && op == lmx_pkg::LMX_OP_SRST);
        end
    end

    // literal loads; no status logic lives here
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            work_r <= 8'h00;
            bank_select_reg_r <= 6'h00;
            pc_high_latch_r <= 7'h00;
        end
        else if (soft_reset_r)
        begin
            work_r <= 8'h00;
            bank_select_reg_r <= 6'h00;
            pc_high_latch_r <= 7'h00;
        end
        else if (take)
        begin
            if (op == lmx_pkg::LMX_OP_BANK)
                bank_select_reg_r <= instr[5:0];
            if (op == lmx_pkg::LMX_OP_PAGE)
                pc_high_latch_r <= instr[6:0];
            if (op == lmx_pkg::LMX_OP_WORK)
                work_r <= instr[7:0];
        end
    end

    // data memory writes, direct and indirect
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mem_we_r <= 1'b0;
            mem_indirect_r <= 1'b0;
            mem_addr_r <= 16'h0000;
            mem_data_r <= 8'h00;
        end
        else
        begin
            mem_we_r <= 1'b0;
            if (take && (op == lmx_pkg::LMX_OP_FILE ||
                op == lmx_pkg::LMX_OP_IND || op == lmx_pkg::LMX_OP_REL))
            begin
                mem_we_r <= 1'b1;
                mem_data_r <= work_r;
                if (op == lmx_pkg::LMX_OP_FILE && !window_hit)
                begin
                    mem_indirect_r <= 1'b0;
                    mem_addr_r <= {3'h0, bank_select_reg_r, instr[6:0]};
                end
                else
                begin
                    mem_indirect_r <= 1'b1;
                    mem_addr_r <= eff_addr;
                end
            end
        end
    end

    // pointers; status bits are never touched by these updates
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ptr0_r <= 16'h0000;
            ptr1_r <= 16'h0000;
        end
        else if (soft_reset_r)
        begin
            ptr0_r <= 16'h0000;
            ptr1_r <= 16'h0000;
        end
        else if (take && op == lmx_pkg::LMX_OP_IND)
        begin
            if (sel)
                ptr1_r <= ptr_next;
            else
                ptr0_r <= ptr_next;
        end
    end

    // return from interrupt and software reset
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pc_load_r <= 1'b0;
            pc_value_r <= 15'h0000;
            stack_pop_r <= 1'b0;
            irq_control_reg_r <= 8'h00;
            soft_reset_r <= 1'b0;
            reset_instr_flag_r <= `LMX_RI_RESET;
        end
        else
        begin
            pc_load_r <= 1'b0;
            stack_pop_r <= 1'b0;
            soft_reset_r <= take && op == lmx_pkg::LMX_OP_SRST;
            if (soft_reset_r)
            begin
                irq_control_reg_r <= 8'h00;
                pc_value_r <= 15'h0000;
                pc_load_r <= 1'b1;
            end
            else if (take && op == lmx_pkg::LMX_OP_SRST)
                reset_instr_flag_r <= 1'b0;
            else if (take && op == lmx_pkg::LMX_OP_RETI)
            begin
                pc_load_r <= 1'b1;
                pc_value_r <= stack_top;
                stack_pop_r <= 1'b1;
                irq_control_reg_r[`LMX_GIE_BIT] <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    sequence s_reti_taken;
        instr_valid && instr_ready_r && !soft_reset_r &&
            instr == `LMX_RETI_VAL;
    endsequence
    a_bank_literal_load: assert property (
        (take && op == lmx_pkg::LMX_OP_BANK) |=>
            bank_select_reg_r == $past(instr[5:0]))
        else $error("bank literal not loaded");
    a_page_literal_load: assert property (
        (take && op == lmx_pkg::LMX_OP_PAGE) |=>
            pc_high_latch_r == $past(instr[6:0]))
        else $error("page latch literal not loaded");
    a_work_literal_load: assert property (
        (take && op == lmx_pkg::LMX_OP_WORK) |=>
            work_r == $past(instr[7:0]) && instr_ready_r)
        else $error("work literal not loaded in one cycle");
    a_file_store_write: assert property (
        (take && op == lmx_pkg::LMX_OP_FILE && !window_hit) |=>
            mem_we_r && !mem_indirect_r && mem_data_r == $past(work_r))
        else $error("direct store missing");
    a_window_redirect: assert property (
        (take && window_hit) |=> mem_we_r && mem_indirect_r &&
            mem_addr_r == ($past(instr[0]) ? $past(ptr1_r) :
            $past(ptr0_r)))
        else $error("window access not redirected");
    a_preinc_address: assert property (
        (take && op == lmx_pkg::LMX_OP_IND && instr[1:0] == 2'h0 &&
            !instr[2]) |=> mem_addr_r == 16'($past(ptr0_r) + 16'h0001)
            && ptr0_r == mem_addr_r)
        else $error("preincrement address wrong");
    a_postdec_pointer: assert property (
        (take && op == lmx_pkg::LMX_OP_IND && instr[1:0] == 2'h3 &&
            instr[2]) |=> ptr1_r == 16'($past(ptr1_r) - 16'h0001) &&
            mem_addr_r == $past(ptr1_r))
        else $error("postdecrement pointer wrong");
    a_relative_keeps_ptr: assert property (
        (take && op == lmx_pkg::LMX_OP_REL) |=>
            $stable(ptr0_r) && $stable(ptr1_r))
        else $error("relative store moved pointer");
    a_reti_two_cycles: assert property (
        s_reti_taken |=> pc_load_r && stack_pop_r && !instr_ready_r &&
            pc_value_r == $past(stack_top) ##1 instr_ready_r)
        else $error("return sequence wrong");
    a_reti_sets_gie: assert property (
        s_reti_taken |=> irq_control_reg_r[7])
        else $error("global enable not set");
    a_soft_reset_flag: assert property (
        (take && op == lmx_pkg::LMX_OP_SRST) |=> soft_reset_r &&
            !reset_instr_flag_r ##1 ptr0_r == 16'h0000 && work_r == 8'h00)
        else $error("software reset incomplete");
    a_nop_no_change: assert property (
        (take && op == lmx_pkg::LMX_OP_NOP) |=> !mem_we_r && !pc_load_r &&
            $stable(work_r) && $stable(ptr0_r) && $stable(ptr1_r))
        else $error("nop changed state");
endmodule // lmx_exec

/* File: design/lmx_params.svh */
/*
 * constants for the literal/move/indirect/return execution block:
 * opcode masks and values, field positions, reset values.
 * assumes 14-bit instruction words.
 */
`ifndef LMX_PARAMS_SVH
`define LMX_PARAMS_SVH

`define LMX_IW 14
`define LMX_NOP_VAL 14'h0000
`define LMX_SRST_VAL 14'h0001
`define LMX_RETI_VAL 14'h0009
`define LMX_BANK_MASK 14'h3fc0
`define LMX_BANK_VAL 14'h0140
`define LMX_PAGE_MASK 14'h3f80
`define LMX_PAGE_VAL 14'h3180
`define LMX_WORK_MASK 14'h3f00
`define LMX_WORK_VAL 14'h3000
`define LMX_FILE_MASK 14'h3f80
`define LMX_FILE_VAL 14'h0080
`define LMX_IND_MASK 14'h3ff8
`define LMX_IND_VAL 14'h0018
`define LMX_REL_MASK 14'h3f80
`define LMX_REL_VAL 14'h3f80
`define LMX_IND_SEL_BIT 2
`define LMX_REL_SEL_BIT 6
`define LMX_MODE_PRE_INC 2'h0
`define LMX_MODE_PRE_DEC 2'h1
`define LMX_MODE_POST_INC 2'h2
`define LMX_MODE_POST_DEC 2'h3
`define LMX_WINDOW0_ADDR 7'h00
`define LMX_WINDOW1_ADDR 7'h01
`define LMX_GIE_BIT 7
`define LMX_RI_RESET 1'b1
`define LMX_RETI_CYCLES 2

`endif

/* File: design/lmx_pkg.sv */
/*
 * types for the literal/move/indirect/return execution block.
 * assumes nothing beyond the params header.
 */
package lmx_pkg;
    typedef enum logic [1:0] {
        LMX_ST_RUN = 2'b01,
        LMX_ST_RET2 = 2'b10
    } lmx_state_t;

    typedef enum logic [3:0] {
        LMX_OP_NOP,
        LMX_OP_BANK,
        LMX_OP_PAGE,
        LMX_OP_WORK,
        LMX_OP_FILE,
        LMX_OP_IND,
        LMX_OP_REL,
        LMX_OP_SRST,
        LMX_OP_RETI,
        LMX_OP_OTHER
    } lmx_op_t;
endpackage

/* File: design/lmx_ptr_unit.sv */
/*
 * indirect pointer address unit: effective address and updated pointer.
 * assumes a 16-bit pointer and a 2-bit update mode.
 */
`timescale 1ns/1ns
`include "lmx_params.svh"

module lmx_ptr_unit (
    input wire logic [15:0] ptr,
    input wire logic [1:0] pointer_update_mode,
    input wire logic rel,
    input wire logic [5:0] offset,
    output logic [15:0] eff_addr,
    output logic [15:0] ptr_next
);
    logic [15:0] plus_one;
    logic [15:0] minus_one;
    logic [15:0] plus_off;

    // 16-bit sums wrap modulo the pointer range
    assign plus_one = 16'(ptr + 16'h0001);
    assign minus_one = 16'(ptr - 16'h0001);
    assign plus_off = 16'(ptr + {{10{offset[5]}}, offset});

    always_comb
    begin
        if (rel)
        begin
            eff_addr = plus_off;
            ptr_next = ptr;
        end
        else
        begin
            case (pointer_update_mode)
                `LMX_MODE_PRE_INC:
                begin
                    eff_addr = plus_one;
                    ptr_next = plus_one;
                end
                `LMX_MODE_PRE_DEC:
                begin
                    eff_addr = minus_one;
                    ptr_next = minus_one;
                end
                `LMX_MODE_POST_INC:
                begin
                    eff_addr = ptr;
                    ptr_next = plus_one;
                end
                default:
                begin
                    eff_addr = ptr;
                    ptr_next = minus_one;
                end
            endcase
        end
    end
endmodule // lmx_ptr_unit

/* File: testbench/lmx_prog_mem.sv */
/*
 * program memory model: presents queued instruction words in order.
 * assumes the executor takes a word at a rising edge of mclk while
 * instr_ready_r is high and soft_reset_r is low.
 */
`timescale 1ns/1ns

module lmx_prog_mem (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic instr_ready_r,
    input wire logic soft_reset_r,
    output logic instr_valid,
    output logic [13:0] instr
);
    logic [13:0] q[$];
    logic taken;

    assign taken = instr_valid && instr_ready_r && !soft_reset_r;

    // word held until taken; idle line toggles, slow adds a gap
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            instr_valid <= 1'b0;
            instr <= 14'h0000;
        end
        else
        begin
            if (taken)
                void'(q.pop_front());
            if (q.size() != 0 && !(taken && slow))
            begin
                instr_valid <= 1'b1;
                instr <= q[0];
            end
            else
            begin
                instr_valid <= 1'b0;
                instr <= ~instr;
            end
        end
    end
endmodule // lmx_prog_mem

/* File: testbench/test_literal_move_indirect_return_exec.sv */
/*
 * testbench for lmx_exec: queues programs into the memory model and
 * checks registers, write pulses and pc loads.
 * assumes lmx_exec and lmx_prog_mem are compiled first.
 */
`timescale 1ns/1ns

module test_literal_move_indirect_return_exec;
    logic mclk, reset_n, slow, instr_valid, instr_ready_r, pc_load_r;
    logic [13:0] instr;
    logic [14:0] stack_top, pc_value_r;
    logic [7:0] work_r, irq_control_reg_r, mem_data_r;
    logic [5:0] bank_select_reg_r;
    logic [6:0] pc_high_latch_r;
    logic stack_pop_r, mem_we_r, mem_indirect_r, soft_reset_r;
    logic [15:0] mem_addr_r, ptr0_r, ptr1_r;
    logic reset_instr_flag_r;
    int fails, n_checks, busy, n_srst;
    logic [24:0] wq[$], ewq[$];
    logic [15:0] pq[$];
    logic [13:0] prog[$];
    logic [15:0] p[2];
    logic [7:0] w;
    logic [5:0] b;

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    lmx_exec i_dut (.mclk, .reset_n, .instr_valid, .instr, .stack_top,
        .instr_ready_r, .work_r, .bank_select_reg_r, .pc_high_latch_r,
        .pc_load_r, .pc_value_r, .stack_pop_r, .irq_control_reg_r,
        .mem_we_r, .mem_indirect_r, .mem_addr_r, .mem_data_r, .ptr0_r,
        .ptr1_r, .soft_reset_r, .reset_instr_flag_r);
    lmx_prog_mem i_mem (.mclk, .reset_n, .slow, .instr_ready_r,
        .soft_reset_r, .instr_valid, .instr);

    // monitor write pulses, pc loads and refused cycles
    always @(posedge mclk)
    begin
        if (mem_we_r === 1'b1)
            wq.push_back({mem_indirect_r, mem_addr_r, mem_data_r});
        if (pc_load_r === 1'b1)
            pq.push_back({stack_pop_r, pc_value_r});
        if (instr_valid && !instr_ready_r)
            busy++;
        if (soft_reset_r === 1'b1)
            n_srst++;
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task conclude();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // hand queued words to memory, wait until all are taken
    task go();
        int n;
        @(negedge mclk);
        busy = 0;
        foreach (prog[i])
            i_mem.q.push_back(prog[i]);
        prog.delete();
        n = 0;
        while (i_mem.q.size() != 0 && n < 200)
        begin
            @(negedge mclk);
            n++;
        end
        repeat (3) @(negedge mclk);
        check(n < 200, 1'b1);
    endtask

    task flush();
        check(wq.size(), ewq.size());
        while (wq.size() != 0 && ewq.size() != 0)
            check({7'h0, wq.pop_front()}, {7'h0, ewq.pop_front()});
        wq.delete();
        ewq.delete();
    endtask

    task lw(input logic [7:0] k);
        w = k;
        prog.push_back({6'h30, k});
    endtask

    task sf(input logic [6:0] f);
        if (f[6:1] == 6'h00)
            ewq.push_back({1'b1, p[f[0]], w});
        else
            ewq.push_back({1'b0, 3'h0, b, f, w});
        prog.push_back({7'h01, f});
    endtask

    task si(input logic n, input logic [1:0] mm);
        logic [15:0] a;
        a = mm[1] ? p[n] : (mm[0] ? p[n] - 16'h1 : p[n] + 16'h1);
        p[n] = mm[0] ? p[n] - 16'h1 : p[n] + 16'h1;
        ewq.push_back({1'b1, a, w});
        prog.push_back({9'h0, 2'b11, n, mm});
    endtask

    task sr(input logic n, input logic [5:0] k);
        ewq.push_back({1'b1, p[n] + {{10{k[5]}}, k}, w});
        prog.push_back({7'h7f, n, k});
    endtask

    task regs(input logic [7:0] ew, input logic [5:0] eb,
        input logic [6:0] el, input logic [7:0] ei);
        check({work_r, bank_select_reg_r, pc_high_latch_r, irq_control_reg_r},
            {ew, eb, el, ei});
        check({ptr0_r, ptr1_r}, {p[0], p[1]});
    endtask

    initial
    begin
        reset_n = 1'b0;
        slow = 1'b0;
        stack_top = 15'h0000;
        fails = 0;
        n_checks = 0;
        p[0] = 16'h0000;
        p[1] = 16'h0000;
        w = 8'h00;
        b = 6'h00;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
        check({instr_ready_r, reset_instr_flag_r, pc_load_r, mem_we_r},
            4'hc);
        regs(8'h00, 6'h00, 7'h00, 8'h00);
        $display("test reset done");

        // literal loads at the field limits, then nop and an unknown word
        prog.push_back({8'h05, 6'h3f});
        prog.push_back({7'h63, 7'h7f});
        lw(8'hff);
        prog.push_back(14'h0000);
        prog.push_back(14'h2000);
        go();
        b = 6'h3f;
        regs(8'hff, 6'h3f, 7'h7f, 8'h00);
        check(busy, 0);
        flush();
        $display("test literals done");

        // direct stores use bank and 7-bit address
        lw(8'ha5);
        sf(7'h7f);
        sf(7'h20);
        go();
        flush();
        check(busy, 0);
        $display("test file store done");

        // every pointer mode, wrap at both ends, back to back
        lw(8'h3c);
        si(1'b0, 2'h1);
        si(1'b0, 2'h0);
        si(1'b1, 2'h2);
        lw(8'hc3);
        si(1'b1, 2'h3);
        si(1'b1, 2'h3);
        si(1'b0, 2'h2);
        go();
        flush();
        regs(8'hc3, 6'h3f, 7'h7f, 8'h00);
        check(busy, 0);
        $display("test indirect done");

        // relative offsets at both limits, window redirect, slow memory
        slow <= 1'b1;
        sr(1'b0, 6'h20);
        sr(1'b1, 6'h1f);
        sf(7'h00);
        sf(7'h01);
        go();
        flush();
        regs(8'hc3, 6'h3f, 7'h7f, 8'h00);
        slow <= 1'b0;
        $display("test relative done");

        // return from interrupt
        @(posedge mclk);
        stack_top <= 15'h4321;
        prog.push_back(14'h0009);
        prog.push_back(14'h0000);
        go();
        check(pq.size(), 1);
        check(pq.pop_front(), {1'b1, 15'h4321});
        check(busy, 1);
        regs(8'hc3, 6'h3f, 7'h7f, 8'h80);
        $display("test return done");

        // software reset, then a load after it
        prog.push_back(14'h0001);
        lw(8'h12);
        go();
        p[0] = 16'h0000;
        p[1] = 16'h0000;
        check(pq.size(), 1);
        check(pq.pop_front(), 16'h0000);
        check(reset_instr_flag_r, 1'b0);
        check(n_srst, 1);
        check(busy, 1);
        regs(8'h12, 6'h00, 7'h00, 8'h00);
        flush();
        $display("test soft reset done");
        conclude();
    end

    // cut a hang short
    initial
    begin
        #(40 * 20000);
        fails++;
        conclude();
    end
endmodule // test_literal_move_indirect_return_exec
